// File: common/ada_pkg.sv
// Constants for the dual actuator slave application logic.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package ada_pkg;
    // ------------------------------------------------------------
    // Profile codes
    // ------------------------------------------------------------
    localparam logic [3:0] ADA_IO_CODE = 4'hb;
    // Arbitrary neutral identity value, not tied to any real part
    localparam logic [3:0] ADA_ID_CODE_DEF = 4'h5;
    // ------------------------------------------------------------
    // Wire levels: the line carries LOW as 0 and HIGH as 1
    // ------------------------------------------------------------
    localparam logic ADA_LVL_LOW = 1'b0;
    localparam logic ADA_LVL_HIGH = 1'b1;
    localparam logic [3:0] ADA_PARAM_ECHO = 4'hf;
    // ------------------------------------------------------------
    // Bit positions in the data and parameter nibbles
    // ------------------------------------------------------------
    localparam int ADA_D_ACT1 = 0;
    localparam int ADA_D_ACT2 = 1;
    localparam int ADA_D_FB1 = 2;
    localparam int ADA_D_FB2 = 3;
    localparam int ADA_P_WDOG = 0;
    localparam int ADA_P_ILOCK = 1;
    localparam int ADA_P_RRST = 2;
    localparam int ADA_P_SPEC = 3;
    // ------------------------------------------------------------
    // Register map of the local port
    // ------------------------------------------------------------
    localparam logic [3:0] ADA_REG_STATUS = 4'h0;
    localparam logic [3:0] ADA_REG_CODES = 4'h1;
    localparam logic [3:0] ADA_REG_PARAM = 4'h2;
    // ------------------------------------------------------------
    // Watchdog timing
    // ------------------------------------------------------------
    localparam int ADA_CLK_HZ = 20_000_000;
    localparam int ADA_WDOG_MS = 25;
    localparam int ADA_WDOG_CYC = ADA_WDOG_MS * (ADA_CLK_HZ / 1000);
    localparam int ADA_WDOG_W = 20;
endpackage

// File: verilog/ada_slave.sv
// Application side of a two-actuator slave with feedback.
// Assumes a link front end presenting decoded frames as one-cycle strobes.
// Watchdog length is a parameter; keep it above 20 ms worth of clock cycles.
//
// What this block does
// RULE1 - Configuration read returns I/O code hex B
// RULE2 - Fixed identity code, never changed by master
// RULE3 - act1_cmd 1 energizes actuator one, 0 releases
// RULE4 - act2_cmd 1 energizes actuator two, 0 releases
// RULE5 - act1_feedback high means actuator one energized
// RULE6 - act2_feedback high means actuator two energized
// RULE7 - wdog_param low enables communication watchdog
// RULE8 - Watchdog trips only after more than 20 ms
// RULE9 - Watchdog trip de-energizes both actuators
// RULE10 - interlock_param low enables mutual interlock
// RULE11 - Both commanded while interlocked releases both
// RULE12 - remote_reset_param low starts remote reset
// RULE13 - Remote reset drives actuators to rest state
// RULE14 - special_param low selects special function
// RULE15 - Parameter request answers all bits HIGH
// RULE16 - Outputs released after reset until first command
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ada_slave
    import ada_pkg::*;
#(
    parameter int WDOG_CYCLES = ADA_WDOG_CYC,
    parameter logic [3:0] ID_CODE = ADA_ID_CODE_DEF
) (
    input wire logic clock,
    input wire logic sys_rst,
    // Decoded link traffic
    input wire logic data_strobe,
    input wire logic [1:0] data_out_bits,
    input wire logic param_strobe,
    input wire logic [3:0] param_bits,
    input wire logic cfg_strobe,
    // Local feedback contacts
    input wire logic act1_fb_in,
    input wire logic act2_fb_in,
    // Responses back to the link
    output logic [3:0] resp_data,
    output logic [3:0] resp_param,
    output logic [3:0] resp_io_code,
    output logic [3:0] resp_id_code,
    output logic resp_valid,
    // Actuator drives
    output logic act1_drive,
    output logic act2_drive,
    output logic special_mode,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Gray coded along idle -> run -> tripped
    typedef enum logic [1:0] {
        ADA_ST_IDLE = 2'b00,
        ADA_ST_RUN = 2'b01,
        ADA_ST_TRIP = 2'b11
    } ada_state_t;

    // Interlock filter on the controller-level command pair
    function automatic logic [1:0] ada_gate(input logic [1:0] cmd, input logic ilock);
        ada_gate = (ilock && (&cmd)) ? 2'b00 : cmd; // RULE11
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ada_state_t st_q, st_d; // Link supervision state
    logic [1:0] cmd_q, cmd_d; // Last command, controller level
    logic [3:0] par_q, par_d; // Parameter nibble, line level
    logic [ADA_WDOG_W-1:0] wd_q, wd_d; // Silence counter
    logic [1:0] drv_q, drv_d; // Registered actuator drives
    // Reply registers toward the link
    logic [3:0] rdat_q, rdat_d; // Data reply, outputs read HIGH
    logic [3:0] rpar_q, rpar_d; // Parameter reply, all HIGH
    logic [3:0] rio_q, rio_d; // I/O configuration code
    logic [3:0] rid_q, rid_d; // Identity code
    logic rv_q, rv_d; // Reply strobe, one cycle
    logic spec_q, spec_d; // Special function selected
    logic [7:0] rd_q, rd_d; // Register read data, one cycle
    logic trip_cnt_q, trip_cnt_d; // Sticky trip seen, readable
    // Decoded parameter levels
    logic wd_en; // Watchdog armed
    logic ilock_en; // Mutual interlock armed
    logic rreset; // Remote reset held
    logic act_frame; // Any frame this cycle

    // Parameter decode; each one is active at line LOW
    assign wd_en = (par_q[ADA_P_WDOG] == ADA_LVL_LOW); // RULE7
    assign ilock_en = (par_q[ADA_P_ILOCK] == ADA_LVL_LOW); // RULE10
    assign rreset = (par_q[ADA_P_RRST] == ADA_LVL_LOW); // RULE12
    assign act_frame = data_strobe | param_strobe | cfg_strobe;

    // ------------------------------------------------------------
    // Command, watchdog and drive logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        par_d = par_q;
        wd_d = wd_q;
        trip_cnt_d = trip_cnt_q;
        spec_d = (par_q[ADA_P_SPEC] == ADA_LVL_LOW); // RULE14
        // Parameter nibble is stored at line level
        if (param_strobe) begin
            par_d = param_bits;
        end
        if (data_strobe) begin
            // Line LOW energizes, so invert to controller level
            cmd_d = ~data_out_bits; // RULE3 RULE4
        end
        // Any frame addressed to us counts as activity
        // The count saturates, so a long silence never wraps to look fresh
        if (act_frame) begin
            wd_d = '0;
        end else if (wd_q != ADA_WDOG_W'(WDOG_CYCLES)) begin
            wd_d = wd_q + 1'b1;
        end
        // Link supervision: idle until a command, run, trip on silence
        case (st_q)
            ADA_ST_IDLE: begin
                // Held released until a first command arrives
                if (data_strobe) begin // RULE16
                    st_d = ADA_ST_RUN;
                end
            end
            ADA_ST_RUN: begin
                // Trip needs WDOG_CYCLES+1 quiet cycles in a row
                if (wd_en && !act_frame && wd_q == ADA_WDOG_W'(WDOG_CYCLES)) begin
                    st_d = ADA_ST_TRIP; // RULE8
                    trip_cnt_d = 1'b1;
                end
            end
            ADA_ST_TRIP: begin
                // Recovery needs a fresh command, not just any frame
                if (data_strobe) begin
                    st_d = ADA_ST_RUN;
                end
            end
            default: begin
                st_d = ADA_ST_IDLE;
            end
        endcase
        if (rreset) begin
            // Remote reset returns to rest and clears the trip
            st_d = ADA_ST_IDLE; // RULE13
            cmd_d = 2'b00;
        end
        // Software clears the sticky trip flag through the status word
        if (reg_wr && reg_addr == ADA_REG_STATUS && reg_wdata[0]) begin
            trip_cnt_d = 1'b0;
        end
        if (st_q == ADA_ST_RUN && wd_en && !act_frame
            && wd_q == ADA_WDOG_W'(WDOG_CYCLES)) begin
            trip_cnt_d = 1'b1; // Set wins over a same-cycle clear
        end
        // Drives only in run state; trip and idle release both
        if (st_q == ADA_ST_RUN) begin
            drv_d = ada_gate(cmd_q, ilock_en); // RULE9 RULE11
        end else begin
            drv_d = 2'b00;
        end
    end

    // ------------------------------------------------------------
    // Responses and register read
    // ------------------------------------------------------------
    // Replies are registered so every port comes from a flop
    always_comb begin
        rdat_d = rdat_q;
        rpar_d = rpar_q;
        rio_d = ADA_IO_CODE; // RULE1
        rid_d = ID_CODE; // RULE2
        rv_d = act_frame;
        // Outputs echo HIGH, feedback bits report contacts
        rdat_d[ADA_D_ACT1] = ADA_LVL_HIGH;
        rdat_d[ADA_D_ACT2] = ADA_LVL_HIGH;
        rdat_d[ADA_D_FB1] = act1_fb_in; // RULE5
        rdat_d[ADA_D_FB2] = act2_fb_in; // RULE6
        rpar_d = ADA_PARAM_ECHO; // RULE15
        // Read data stand one cycle, zero otherwise
        rd_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADA_REG_STATUS: rd_d = {2'b00, st_q, drv_q, act2_fb_in, trip_cnt_q};
                ADA_REG_CODES: rd_d = {ID_CODE, ADA_IO_CODE};
                ADA_REG_PARAM: rd_d = {2'b00, cmd_q, par_q};
                default: rd_d = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Synchronous reset; every register updates on every edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= ADA_ST_IDLE;
            cmd_q <= 2'b00;
            par_q <= ADA_PARAM_ECHO;
            wd_q <= '0;
            drv_q <= 2'b00;
            trip_cnt_q <= 1'b0;
            spec_q <= 1'b0;
            rdat_q <= ADA_PARAM_ECHO;
            rpar_q <= ADA_PARAM_ECHO;
            rio_q <= ADA_IO_CODE;
            rid_q <= ID_CODE;
            rv_q <= 1'b0;
            rd_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            par_q <= par_d;
            wd_q <= wd_d;
            drv_q <= drv_d;
            trip_cnt_q <= trip_cnt_d;
            spec_q <= spec_d;
            rdat_q <= rdat_d;
            rpar_q <= rpar_d;
            rio_q <= rio_d;
            rid_q <= rid_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
        end
    end

    // Ports are plain flop copies, no logic after the registers
    assign act1_drive = drv_q[0];
    assign act2_drive = drv_q[1];
    assign special_mode = spec_q;
    assign resp_data = rdat_q;
    assign resp_param = rpar_q;
    assign resp_io_code = rio_q;
    assign resp_id_code = rid_q;
    assign resp_valid = rv_q;
    assign reg_rdata = rd_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Both actuators asked for while the interlock is armed
    sequence s_both_cmd;
        st_q == ADA_ST_RUN && ilock_en && (&cmd_q);
    endsequence

    // A command taken, then the run state with no interlock
    sequence s_cmd_in_run;
        data_strobe && !rreset ##1 st_q == ADA_ST_RUN && !ilock_en;
    endsequence

    // Codes toward the master
    chk_io_code: assert property (@(posedge clock) disable iff (sys_rst) // RULE1
        resp_io_code == 4'hb) else $error("io code wrong");
    chk_id_fixed: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
        $stable(resp_id_code)) else $error("id code changed");

    // Command and feedback levels
    chk_cmd_act1: assert property (@(posedge clock) disable iff (sys_rst) // RULE3
        s_cmd_in_run |=> act1_drive == ~$past(data_out_bits[0], 2)) else $error("act1 level");
    chk_cmd_act2: assert property (@(posedge clock) disable iff (sys_rst) // RULE4
        s_cmd_in_run |=> act2_drive == ~$past(data_out_bits[1], 2)) else $error("act2 level");
    chk_fb_one: assert property (@(posedge clock) disable iff (sys_rst) // RULE5
        1'b1 |=> resp_data[ADA_D_FB1] == $past(act1_fb_in)) else $error("fb1");
    chk_fb_two: assert property (@(posedge clock) disable iff (sys_rst) // RULE6
        1'b1 |=> resp_data[ADA_D_FB2] == $past(act2_fb_in)) else $error("fb2");

    // Watchdog; the checks use the saturated count, not wall time
    chk_wdog_off: assert property (@(posedge clock) disable iff (sys_rst) // RULE7
        st_q == ADA_ST_RUN && !wd_en |=> st_q != ADA_ST_TRIP) else $error("trip while off");
    chk_wdog_trip: assert property (@(posedge clock) disable iff (sys_rst) // RULE8
        st_q == ADA_ST_TRIP && $changed(st_q)
        |-> $past(wd_en) && $past(wd_q) == ADA_WDOG_W'(WDOG_CYCLES)) else $error("early trip");
    chk_trip_drop: assert property (@(posedge clock) disable iff (sys_rst) // RULE9
        st_q == ADA_ST_TRIP |=> !act1_drive && !act2_drive) else $error("drive on trip");

    // Interlock, remote reset and parameter handling
    chk_ilock_both: assert property (@(posedge clock) disable iff (sys_rst) // RULE11
        s_both_cmd |=> !act1_drive && !act2_drive) else $error("interlock");
    chk_ilock_off: assert property (@(posedge clock) disable iff (sys_rst) // RULE10
        st_q == ADA_ST_RUN && !ilock_en |=> {act2_drive, act1_drive} == $past(cmd_q))
        else $error("no interlock");
    chk_rreset_rest: assert property (@(posedge clock) disable iff (sys_rst) // RULE13
        rreset |=> st_q == ADA_ST_IDLE && cmd_q == 2'b00 ##1 !act1_drive && !act2_drive)
        else $error("remote reset");
    chk_spec_mode: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
        param_strobe |-> ##2 special_mode == !$past(param_bits[ADA_P_SPEC], 2))
        else $error("special mode");
    chk_param_echo: assert property (@(posedge clock) disable iff (sys_rst) // RULE15
        param_strobe |=> resp_param == 4'hf && resp_valid) else $error("param echo");
    chk_reset_idle: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
        st_q == ADA_ST_IDLE |=> !act1_drive && !act2_drive) else $error("idle drive");
endmodule
`default_nettype wire

// File: bench/ada_master_model.sv
// Master-side model: sends data, parameter and configuration frames.
// Assumes the slave takes each one-cycle strobe on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ada_master_model (
    input wire logic clock,
    output var logic data_strobe,
    output var logic [1:0] data_out_bits,
    output var logic param_strobe,
    output var logic [3:0] param_bits,
    output var logic cfg_strobe
);
    // ----------------------------------------
    // Idle levels at time zero
    // ----------------------------------------
    initial begin
        data_strobe = 1'b0;
        data_out_bits = 2'h3;
        param_strobe = 1'b0;
        param_bits = 4'hf;
        cfg_strobe = 1'b0;
    end
    // Data frame; lines show the inverse after the frame, never a stale copy
    task automatic send_data(input logic [1:0] b);
        @(posedge clock);
        data_strobe <= 1'b1;
        data_out_bits <= b;
        @(posedge clock);
        data_strobe <= 1'b0;
        data_out_bits <= ~b;
    endtask
    // Parameter frame, same release policy as data
    task automatic send_param(input logic [3:0] p);
        @(posedge clock);
        param_strobe <= 1'b1;
        param_bits <= p;
        @(posedge clock);
        param_strobe <= 1'b0;
        param_bits <= ~p;
    endtask
    // Configuration and identity request
    task automatic send_cfg();
        @(posedge clock);
        cfg_strobe <= 1'b1;
        @(posedge clock);
        cfg_strobe <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: bench/ada_slave_tb_top.sv
// Testbench: frames go through the master model, results are compared
// with an integer model. Assumes a short watchdog count for simulation.
`timescale 1ns/1ps
`default_nettype none
module ada_slave_tb_top;
    import ada_pkg::*;
    localparam int WDOG_SIM = 50; // Short watchdog so the run stays brief
    localparam logic [3:0] ID_SIM = 4'h6; // Arbitrary identity value
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic data_strobe, param_strobe, cfg_strobe;
    logic [1:0] data_out_bits;
    logic [3:0] param_bits, resp_data, resp_param, resp_io_code, resp_id_code;
    logic act1_fb_in = 1'b0, act2_fb_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic resp_valid, act1_drive, act2_drive, special_mode;
    int error_cnt = 0, checks = 0, run = 0, cmd = 0, par = 15; // Reference state
    always #25 clock = ~clock;
    ada_master_model i_ada_master_model (.clock(clock), .data_strobe(data_strobe),
        .data_out_bits(data_out_bits), .param_strobe(param_strobe),
        .param_bits(param_bits), .cfg_strobe(cfg_strobe));
    ada_slave #(.WDOG_CYCLES(WDOG_SIM), .ID_CODE(ID_SIM)) i_ada_slave (.clock(clock),
        .sys_rst(sys_rst), .data_strobe(data_strobe), .data_out_bits(data_out_bits),
        .param_strobe(param_strobe), .param_bits(param_bits), .cfg_strobe(cfg_strobe),
        .act1_fb_in(act1_fb_in), .act2_fb_in(act2_fb_in), .resp_data(resp_data),
        .resp_param(resp_param), .resp_io_code(resp_io_code),
        .resp_id_code(resp_id_code), .resp_valid(resp_valid), .act1_drive(act1_drive),
        .act2_drive(act2_drive), .special_mode(special_mode), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // ----------------------------------------
    // Compare, verdict and reference model
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Interlock LOW forbids both energized at once
    function automatic logic [1:0] exp_drv();
        if (run == 0) return 2'h0;
        if (cmd == 3 && par[1] == 0) return 2'h0;
        return cmd[1:0];
    endfunction
    task automatic check_drv();
        check("drives", {6'h0, exp_drv()}, {6'h0, act2_drive, act1_drive});
    endtask
    // Data frame with a controller-level command; the line carries it inverted
    task automatic data(input logic [1:0] c);
        logic [1:0] fb;
        fb = 2'($urandom);
        @(posedge clock);
        act1_fb_in <= fb[0];
        act2_fb_in <= fb[1];
        i_ada_master_model.send_data(~c);
        #1;
        check("resp_valid", 8'h01, {7'h0, resp_valid});
        check("resp_data", {4'h0, fb, 2'h3}, {4'h0, resp_data});
        if (par[2] == 0) begin
            run = 0;
            cmd = 0;
        end else begin
            // The first command after reset or a trip applies at once
            run = 1;
            cmd = c;
        end
        @(posedge clock);
        #1;
        check_drv();
    endtask
    task automatic param(input logic [3:0] p);
        i_ada_master_model.send_param(p);
        par = p;
        if (p[2] == 0) begin
            run = 0;
            cmd = 0;
        end
        #1;
        check("resp_param", 8'h0f, {4'h0, resp_param});
        @(posedge clock);
        #1;
        check("special_mode", {7'h0, ~p[3]}, {7'h0, special_mode});
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        $display("mismatch timeout expected 1 seen 0");
        end_of_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] rd;
        int i;
        void'($urandom(32'h345a8889));
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        i_ada_master_model.send_cfg();
        #1;
        check("io_code", 8'h0b, {4'h0, resp_io_code});
        check("id_code", {4'h0, ID_SIM}, {4'h0, resp_id_code});
        reg_read(ADA_REG_CODES, rd);
        check("reg_codes", {ID_SIM, 4'hb}, rd);
        reg_read(4'h7, rd);
        check("reg_unmapped", 8'h00, rd);
        data(2'b11);
        // Every command with interlock on and off, then random mixes
        for (i = 0; i < 40; i++) begin
            param({(i < 8) ? 1'b1 : 1'($urandom), 1'b1, (i < 8) ? i[2] : 1'($urandom), 1'b1});
            data((i < 8) ? i[1:0] : 2'($urandom));
        end
        reg_read(ADA_REG_PARAM, rd);
        check("reg_param", {2'h0, cmd[1:0], par[3:0]}, rd);
        // Remote reset holds the actuators at rest
        param(4'hb);
        data(2'b01);
        param(4'hf);
        data(2'b01);
        data(2'b01);
        // Watchdog: short gap tolerated, long gap trips
        param(4'he);
        data(2'b10);
        repeat (WDOG_SIM - 10) @(posedge clock);
        #1;
        check_drv();
        data(2'b10);
        repeat (WDOG_SIM + 10) @(posedge clock);
        #1;
        run = 0;
        check_drv();
        reg_read(ADA_REG_STATUS, rd);
        check("status_trip", 8'h31, rd & 8'h3d);
        param(4'hf);
        reg_write(ADA_REG_STATUS, 8'h01);
        reg_read(ADA_REG_STATUS, rd);
        check("status_clear", 8'h00, rd & 8'h01);
        data(2'b10);
        data(2'b10);
        repeat (WDOG_SIM + 10) @(posedge clock);
        #1;
        check_drv();
        // Reset in mid-run with both actuators energized
        data(2'b11);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        run = 0;
        cmd = 0;
        par = 15;
        #1;
        check_drv();
        data(2'b11);
        end_of_test();
    end
endmodule
`default_nettype wire
